// *** common/sfis_pkg.sv ***
package sfis_pkg;
    // Core clock rate and derived cycle counts
    localparam int CORE_CLK_HZ = 10_000_000;
    localparam int CORE_PERIOD_NS = 100;
    // Times in microseconds or nanoseconds, as printed; plain defaults where none is given
    localparam int POWER_UP_WAIT_TIME_US = 300;
    localparam int POWER_DOWN_TIME_US = 10;
    localparam int RESTART_PULSE_TIME_NS = 200;
    localparam int RESTART_DURATION_US = 35;
    localparam int RESTART_HOLD_TIME_NS = 50;
    // Least times round up
    localparam int POWER_UP_WAIT_CYC = (POWER_UP_WAIT_TIME_US * 1000 + CORE_PERIOD_NS - 1)
        / CORE_PERIOD_NS;
    localparam int POWER_DOWN_CYC = (POWER_DOWN_TIME_US * 1000 + CORE_PERIOD_NS - 1)
        / CORE_PERIOD_NS;
    localparam int RESTART_PULSE_CYC = (RESTART_PULSE_TIME_NS + CORE_PERIOD_NS - 1)
        / CORE_PERIOD_NS;
    localparam int RESTART_DURATION_CYC = (RESTART_DURATION_US * 1000 + CORE_PERIOD_NS - 1)
        / CORE_PERIOD_NS;
    localparam int RESTART_HOLD_CYC = (RESTART_HOLD_TIME_NS + CORE_PERIOD_NS - 1)
        / CORE_PERIOD_NS;
    localparam int TIMER_W = 16;

    // Interface-level (core) states
    typedef enum logic [2:0] {
        SFIS_OFF = 3'b000,
        SFIS_LOCKOUT = 3'b001,
        SFIS_COLD = 3'b011,
        SFIS_STANDBY = 3'b010,
        SFIS_WARM = 3'b110
    } sfis_core_t;

    // Command phase requested by the command decoder (outside this block)
    typedef enum logic [3:0] {
        PH_INSTR = 4'h0,
        PH_SGL_IN = 4'h1,
        PH_SGL_LAT = 4'h2,
        PH_SGL_OUT = 4'h3,
        PH_DUAL_IN = 4'h4,
        PH_DUAL_LAT = 4'h5,
        PH_DUAL_OUT = 4'h6,
        PH_QPP_ADDR = 4'h7,
        PH_QUAD_IN = 4'h8,
        PH_QUAD_LAT = 4'h9,
        PH_QUAD_OUT = 4'ha,
        PH_DDR_IN = 4'hb,
        PH_DDR_LAT = 4'hc,
        PH_DDR_OUT = 4'hd
    } sfis_phase_t;

    // Width of a phase: single, dual or quad
    typedef enum logic [1:0] {
        WD_SGL = 2'h0,
        WD_DUAL = 2'h1,
        WD_QUAD = 2'h2
    } sfis_width_t;

    localparam logic [3:0] DRIVE_NONE = 4'h0;
    localparam logic [3:0] DRIVE_SO = 4'h2;
    localparam logic [3:0] DRIVE_DUAL = 4'h3;
    localparam logic [3:0] DRIVE_QUAD = 4'hf;
    localparam int INSTR_BITS = 8;
endpackage : sfis_pkg

// *** common/sfis_link_if.sv ***
`timescale 1ns/10ps
// Carries events between the core domain and the link domain
interface sfis_link_if;
    logic accept_cmd;
    logic cmd_active_tgl;
    logic [7:0] instr;
    logic instr_tgl;
    modport core (output accept_cmd, input cmd_active_tgl, input instr, input instr_tgl);
    modport link (input accept_cmd, output cmd_active_tgl, output instr, output instr_tgl);
endinterface : sfis_link_if

// *** verilog/sfis_sync.sv ***
`timescale 1ns/10ps
// Two-flop level synchroniser
module sfis_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    initial begin
        if (W < 1) $error("sfis_sync: W must be at least 1");
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta_reg <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : sfis_sync

// *** verilog/sfis_link.sv ***
`timescale 1ns/10ps
// Logic on the serial clock: instruction shift and data-line ownership
module sfis_link
    import sfis_pkg::*;
(
    input wire logic sck,
    input wire logic cs_b,
    input wire logic rst_b,
    input wire logic hold_b,
    input wire logic quad_en,
    input wire logic [3:0] io_in,
    input wire sfis_pkg::sfis_phase_t phase,
    input wire sfis_pkg::sfis_width_t width,
    input wire logic [3:0] out_data,
    input wire logic ddr_lat_drive,
    sfis_link_if.link lk,
    output logic [3:0] io_out,
    output logic [3:0] io_oe_b,
    output logic [3:0] in_bits
);
    logic [2:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic act_tgl_reg;
    logic paused;
    logic [3:0] drive;

    // Hold only acts outside quad and DDR phases
    assign paused = !hold_b && !quad_en && (phase < PH_QPP_ADDR);

    // Frame starts with chip select low; clock may stand between frames
    always_ff @(posedge sck or posedge cs_b) begin
        if (cs_b) begin
            bit_cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
        end else if (lk.accept_cmd && !paused && phase == PH_INSTR) begin
            shift_reg <= {shift_reg[6:0], io_in[0]};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
    end

    always_ff @(posedge sck or posedge cs_b) begin
        if (cs_b) begin
            act_tgl_reg <= 1'b0;
        end else if (lk.accept_cmd && !paused) begin
            act_tgl_reg <= 1'b1;
        end
    end

    // Word and toggle survive chip select, else each frame end would fake a second arrival
    always_ff @(posedge sck or negedge rst_b) begin
        if (!rst_b) begin
            lk.instr_tgl <= 1'b0;
            lk.instr <= 8'h00;
        end else if (!cs_b && lk.accept_cmd && !paused) begin
            if (phase == PH_INSTR && bit_cnt_reg == 3'h7) begin
                lk.instr <= {shift_reg[6:0], io_in[0]};
                lk.instr_tgl <= !lk.instr_tgl;
            end
        end
    end
    assign lk.cmd_active_tgl = act_tgl_reg;

    // Captured bits for the current width; unused lines read as zero
    always_comb begin
        in_bits = 4'h0;
        if (phase == PH_QPP_ADDR) begin
            in_bits = {3'h0, io_in[0]};
        end else if (phase == PH_SGL_IN || phase == PH_INSTR) begin
            in_bits = {3'h0, io_in[0]};
        end else if (phase == PH_DUAL_IN) begin
            in_bits = {2'h0, io_in[1:0]};
        end else if (phase == PH_QUAD_IN) begin
            in_bits = io_in;
        end else if (phase == PH_DDR_IN) begin
            in_bits = (width == WD_QUAD) ? io_in : (width == WD_DUAL) ? {2'h0, io_in[1:0]}
                : {3'h0, io_in[0]};
        end
    end

    always_comb begin
        drive = DRIVE_NONE;
        unique case (phase)
            PH_SGL_OUT: drive = DRIVE_SO;
            PH_DUAL_OUT: drive = DRIVE_DUAL;
            PH_QUAD_OUT: drive = DRIVE_QUAD;
            PH_DDR_LAT: drive = ddr_lat_drive ? DRIVE_QUAD : DRIVE_NONE;
            PH_DDR_OUT: begin
                if (width == WD_QUAD) drive = DRIVE_QUAD;
                else if (width == WD_DUAL) drive = DRIVE_DUAL;
                else drive = DRIVE_SO;
            end
            // Input phases and the single, dual and quad latency phases keep every line released
            default: drive = DRIVE_NONE;
        endcase
        if (cs_b || !lk.accept_cmd || paused) begin
            drive = DRIVE_NONE;
        end
    end

    assign io_oe_b = ~drive;
    assign io_out = out_data & drive;
endmodule : sfis_link

// *** verilog/sfis_top.sv ***
`timescale 1ns/10ps
module sfis_top
    import sfis_pkg::*;
#(
    parameter int POWER_UP_CYC = POWER_UP_WAIT_CYC,
    parameter int RESTART_CYC = RESTART_DURATION_CYC,
    parameter int PWR_DOWN_CYC = POWER_DOWN_CYC
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic power_good,
    input wire logic supply_ok,
    input wire logic restart_b,
    input wire logic sck,
    input wire logic cs_b,
    input wire logic hold_b,
    input wire logic quad_en,
    input wire sfis_pkg::sfis_phase_t phase,
    input wire sfis_pkg::sfis_width_t width,
    input wire logic [3:0] out_data,
    input wire logic ddr_lat_drive,
    input wire logic [3:0] data_line_in,
    output logic [3:0] data_line_out,
    output logic [3:0] data_line_oe_b,
    output logic [3:0] in_bits,
    output logic cmd_ready,
    output logic prog_erase_allow,
    output logic [7:0] instr_out,
    output logic instr_valid,
    output sfis_pkg::sfis_core_t core_state
);
    sfis_link_if lk ();

    logic pg_s;
    logic sup_s;
    logic rst_pin_s;
    logic itgl_s;
    logic itgl_d_reg;
    logic [TIMER_W-1:0] timer_reg;
    logic [TIMER_W-1:0] pd_cnt_reg;
    logic [TIMER_W-1:0] pulse_cnt_reg;
    logic [TIMER_W-1:0] hold_cnt_reg;
    logic pd_met_reg;
    logic warm_started_reg;
    sfis_core_t state_reg;
    sfis_core_t state_next;

    initial begin
        if (POWER_UP_CYC < 1 || POWER_UP_CYC >= (1 << TIMER_W))
            $error("sfis_top: POWER_UP_CYC out of range");
        if (RESTART_CYC < 1 || RESTART_CYC >= (1 << TIMER_W))
            $error("sfis_top: RESTART_CYC out of range");
        if (PWR_DOWN_CYC < 1 || PWR_DOWN_CYC >= (1 << TIMER_W))
            $error("sfis_top: PWR_DOWN_CYC out of range");
    end

    // Pins cross into the core domain through two flops
    sfis_sync #(.W(3), .RST_VAL(3'b001)) u_pin_sync (
        .clk(core_clk),
        .rst_b(rst_b),
        .d({power_good, supply_ok, restart_b}),
        .q({pg_s, sup_s, rst_pin_s})
    );

    // Instruction arrival travels as a toggle; the word is stable when it flips
    sfis_sync #(.W(1), .RST_VAL(1'b0)) u_itgl_sync (
        .clk(core_clk),
        .rst_b(rst_b),
        .d(lk.instr_tgl),
        .q(itgl_s)
    );

    sfis_link u_link (
        .sck(sck),
        .cs_b(cs_b),
        .rst_b(rst_b),
        .hold_b(hold_b),
        .quad_en(quad_en),
        .io_in(data_line_in),
        .phase(phase),
        .width(width),
        .out_data(out_data),
        .ddr_lat_drive(ddr_lat_drive),
        .lk(lk.link),
        .io_out(data_line_out),
        .io_oe_b(data_line_oe_b),
        .in_bits(in_bits)
    );

    // Time spent powered off, to qualify a cold restart
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pd_cnt_reg <= '0;
            pd_met_reg <= 1'b0;
        end else if (!pg_s) begin
            if (pd_cnt_reg < TIMER_W'(PWR_DOWN_CYC)) pd_cnt_reg <= pd_cnt_reg + 1'b1;
            else pd_met_reg <= 1'b1;
        end else if (state_reg == SFIS_COLD) begin
            pd_cnt_reg <= '0;
            pd_met_reg <= 1'b0;
        end
    end

    // Restart pin low-time and post-rise hold counters
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pulse_cnt_reg <= '0;
            hold_cnt_reg <= '0;
        end else begin
            if (!rst_pin_s) begin
                if (pulse_cnt_reg < TIMER_W'(RESTART_PULSE_CYC))
                    pulse_cnt_reg <= pulse_cnt_reg + 1'b1;
                hold_cnt_reg <= '0;
            end else begin
                pulse_cnt_reg <= '0;
                if (hold_cnt_reg < TIMER_W'(RESTART_HOLD_CYC))
                    hold_cnt_reg <= hold_cnt_reg + 1'b1;
            end
        end
    end

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            SFIS_OFF: begin
                if (pg_s && pd_met_reg) state_next = SFIS_COLD;
                else if (pg_s) state_next = SFIS_LOCKOUT;
            end
            SFIS_LOCKOUT: begin
                if (!pg_s) state_next = SFIS_OFF;
                else if (sup_s && pd_met_reg) state_next = SFIS_COLD;
                else if (sup_s) state_next = SFIS_STANDBY;
            end
            SFIS_COLD: begin
                if (!pg_s) state_next = SFIS_OFF;
                else if (timer_reg == '0) state_next = SFIS_STANDBY;
            end
            SFIS_STANDBY: begin
                if (!pg_s) state_next = SFIS_OFF;
                else if (!sup_s) state_next = SFIS_LOCKOUT;
                else if (pulse_cnt_reg >= TIMER_W'(RESTART_PULSE_CYC))
                    state_next = SFIS_WARM;
            end
            SFIS_WARM: begin
                if (!pg_s) state_next = SFIS_OFF;
                else if (timer_reg == '0 && warm_started_reg && rst_pin_s &&
                         hold_cnt_reg >= TIMER_W'(RESTART_HOLD_CYC))
                    state_next = SFIS_STANDBY;
            end
            default: state_next = SFIS_OFF;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) state_reg <= SFIS_OFF;
        else state_reg <= state_next;
    end

    // Shared countdown for power-up wait and restart duration
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            timer_reg <= '0;
            warm_started_reg <= 1'b0;
        end else if (state_next == SFIS_COLD && state_reg != SFIS_COLD) begin
            timer_reg <= TIMER_W'(POWER_UP_CYC);
        end else if (state_next == SFIS_WARM && state_reg != SFIS_WARM) begin
            timer_reg <= TIMER_W'(RESTART_CYC);
            warm_started_reg <= 1'b1;
        end else begin
            if (timer_reg != '0) timer_reg <= timer_reg - 1'b1;
            if (state_reg != SFIS_WARM) warm_started_reg <= 1'b0;
        end
    end

    // Link only sees a quasi-static accept level; it changes only between frames in practice
    assign lk.accept_cmd = (state_reg == SFIS_STANDBY);
    assign cmd_ready = (state_reg == SFIS_STANDBY);
    assign prog_erase_allow = (state_reg == SFIS_STANDBY) && sup_s;
    assign core_state = state_reg;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            itgl_d_reg <= 1'b0;
            instr_valid <= 1'b0;
            instr_out <= 8'h00;
        end else begin
            itgl_d_reg <= itgl_s;
            instr_valid <= (itgl_s != itgl_d_reg) && cmd_ready;
            if (itgl_s != itgl_d_reg) instr_out <= lk.instr;
        end
    end
endmodule : sfis_top

// *** dv/sfis_monitor.sv ***
`timescale 1ns/10ps
module sfis_monitor
    import sfis_pkg::*;
#(
    parameter int POWER_UP_CYC = 20,
    parameter int RESTART_CYC = 10
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic restart_b,
    input wire logic cs_b,
    input wire logic hold_b,
    input wire logic quad_en,
    input wire sfis_pkg::sfis_phase_t phase,
    input wire sfis_pkg::sfis_width_t width,
    input wire logic [3:0] data_line_oe_b,
    input wire logic cmd_ready,
    input wire logic prog_erase_allow,
    input wire sfis_pkg::sfis_core_t core_state
);
    sfis_core_t st_prev_reg;
    logic [15:0] st_cnt_reg;
    logic act;
    // Samples spent in the previous state, so exits can be timed
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            st_prev_reg <= SFIS_OFF;
            st_cnt_reg <= 16'h0;
        end else begin
            st_prev_reg <= core_state;
            st_cnt_reg <= (core_state == st_prev_reg) ? st_cnt_reg + 16'h1 : 16'h1;
        end
    end
    assign act = !cs_b && cmd_ready;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_left(sfis_core_t s);
        st_prev_reg == s && core_state != s;
    endsequence
    property p_off;
        core_state inside {SFIS_OFF, SFIS_LOCKOUT} |-> !prog_erase_allow && !cmd_ready;
    endproperty
    a_off: assert property (p_off) else $error("supply low but device active");
    property p_quiet;
        !cmd_ready |-> data_line_oe_b == 4'hf;
    endproperty
    a_quiet: assert property (p_quiet) else $error("lines driven outside standby");
    property p_cold;
        s_left(SFIS_COLD) |-> st_cnt_reg >= POWER_UP_CYC;
    endproperty
    a_cold: assert property (p_cold) else $error("power-up wait cut short");
    property p_warm_go;
        (!restart_b && core_state == SFIS_STANDBY) [*4] |-> ##[0:4] core_state == SFIS_WARM;
    endproperty
    a_warm_go: assert property (p_warm_go) else $error("restart pulse not taken");
    property p_warm_len;
        s_left(SFIS_WARM) |-> st_cnt_reg >= RESTART_CYC && $past(restart_b);
    endproperty
    a_warm_len: assert property (p_warm_len) else $error("warm restart left early");
    property p_csh;
        cs_b |-> data_line_oe_b == 4'hf;
    endproperty
    a_csh: assert property (p_csh) else $error("lines driven while deselected");
    property p_out;
        act && hold_b && phase inside {PH_SGL_OUT, PH_DUAL_OUT}
            |-> data_line_oe_b == ((phase == PH_SGL_OUT) ? 4'hd : 4'hc);
    endproperty
    a_out: assert property (p_out) else $error("output phase ownership wrong");
    property p_in;
        act && phase inside {PH_SGL_IN, PH_SGL_LAT, PH_QPP_ADDR, PH_DUAL_IN, PH_QUAD_IN}
            |-> data_line_oe_b == 4'hf;
    endproperty
    a_in: assert property (p_in) else $error("line driven in input phase");
    property p_pause;
        act && !hold_b && !quad_en && phase == PH_SGL_OUT |-> data_line_oe_b == 4'hf;
    endproperty
    a_pause: assert property (p_pause) else $error("line driven while paused");
    property p_ddr;
        act && phase == PH_DDR_OUT |-> data_line_oe_b == ((width == WD_SGL) ? 4'hd
            : (width == WD_DUAL) ? 4'hc : 4'h0);
    endproperty
    a_ddr: assert property (p_ddr) else $error("ddr output ownership wrong");
endmodule : sfis_monitor

bind sfis_top sfis_monitor #(.POWER_UP_CYC(POWER_UP_CYC), .RESTART_CYC(RESTART_CYC)) u_mon (
    .core_clk(core_clk), .rst_b(rst_b), .restart_b(restart_b), .cs_b(cs_b), .hold_b(hold_b),
    .quad_en(quad_en), .phase(phase), .width(width), .data_line_oe_b(data_line_oe_b),
    .cmd_ready(cmd_ready), .prog_erase_allow(prog_erase_allow), .core_state(core_state)
);

// *** dv/sfis_host_model.sv ***
`timescale 1ns/10ps
module sfis_host_model (
    output logic sck,
    output logic cs_b,
    output logic hold_b,
    output logic [3:0] data_line_in
);
    // Serial clock stands still between frames
    initial begin
        sck = 1'b0;
        cs_b = 1'b1;
        hold_b = 1'b1;
        data_line_in = 4'h5;
    end
    // Top n instruction bits on line 0, MSB first; optional pause after bit pz
    task automatic send(input logic [7:0] b, input int n, input int pz);
        cs_b = 1'b0;
        for (int i = 7; i > 7 - n; i--) begin
            data_line_in[0] = b[i];
            #80 sck = 1'b1;
            #80 sck = 1'b0;
            if (i == pz) begin
                hold_b = 1'b0;
                data_line_in[0] = ~b[i];
                repeat (2) begin
                    #80 sck = 1'b1;
                    #80 sck = 1'b0;
                end
                hold_b = 1'b1;
            end
        end
    endtask : send
    // Released lines flip so a stale level never passes for data
    task automatic done();
        #80 cs_b = 1'b1;
        data_line_in = ~data_line_in;
    endtask : done
endmodule : sfis_host_model

// *** dv/tb.sv ***
`timescale 1ns/10ps
module tb;
    import sfis_pkg::*;
    localparam int PU = 20;
    localparam int RS = 10;
    logic core_clk, rst_b, power_good, supply_ok, restart_b, quad_en, ddr_lat_drive;
    logic sck, cs_b, hold_b, cmd_ready, prog_erase_allow, instr_valid;
    logic [3:0] data_line_in, out_data, data_line_out, data_line_oe_b, in_bits, e;
    logic [7:0] instr_out;
    sfis_phase_t phase;
    sfis_width_t width;
    sfis_core_t core_state;
    int n_fail, num_checks;
    logic [7:0] exp_q[$];

    sfis_host_model u_host (.sck(sck), .cs_b(cs_b), .hold_b(hold_b), .data_line_in(data_line_in));
    sfis_top #(.POWER_UP_CYC(PU), .RESTART_CYC(RS), .PWR_DOWN_CYC(5)) u_dut (
        .core_clk(core_clk), .rst_b(rst_b), .power_good(power_good), .supply_ok(supply_ok),
        .restart_b(restart_b), .sck(sck), .cs_b(cs_b), .hold_b(hold_b), .quad_en(quad_en),
        .phase(phase), .width(width), .out_data(out_data), .ddr_lat_drive(ddr_lat_drive),
        .data_line_in(data_line_in), .data_line_out(data_line_out),
        .data_line_oe_b(data_line_oe_b), .in_bits(in_bits), .cmd_ready(cmd_ready),
        .prog_erase_allow(prog_erase_allow), .instr_out(instr_out),
        .instr_valid(instr_valid), .core_state(core_state)
    );

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("TB: checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cyc

    // Extra cycles let the link side see the accept level before a frame
    task automatic wait_ready();
        for (int k = 0; k < 400 && cmd_ready !== 1'b1; k++) @(posedge core_clk);
        cyc(4);
        chk(8'(cmd_ready), 8'h1);
    endtask : wait_ready

    task automatic cmd(input int pz, input bit take);
        logic [7:0] b;
        b = 8'($urandom);
        u_host.send(b, 8, pz);
        if (take)
            exp_q.push_back(b);
        u_host.done();
        cyc(8);
        chk(8'(exp_q.size()), 8'h0);
    endtask : cmd

    function automatic logic [3:0] exp_oe(sfis_phase_t p, sfis_width_t w, logic ld);
        case (p)
            PH_SGL_OUT: return 4'hd;
            PH_DUAL_OUT: return 4'hc;
            PH_QUAD_OUT: return 4'h0;
            PH_DDR_LAT: return ld ? 4'h0 : 4'hf;
            PH_DDR_OUT: return (w == WD_SGL) ? 4'hd : (w == WD_DUAL) ? 4'hc : 4'h0;
            default: return 4'hf;
        endcase
    endfunction : exp_oe

    function automatic logic [3:0] exp_in(sfis_phase_t p, sfis_width_t w, logic [3:0] d);
        case (p)
            PH_SGL_IN, PH_QPP_ADDR: return {3'h0, d[0]};
            PH_DUAL_IN: return {2'h0, d[1:0]};
            PH_QUAD_IN: return d;
            PH_DDR_IN: return (w == WD_QUAD) ? d : (w == WD_DUAL) ? {2'h0, d[1:0]} : {3'h0, d[0]};
            default: return 4'h0;
        endcase
    endfunction : exp_in

    always @(negedge core_clk)
        if (instr_valid === 1'b1)
            chk(instr_out, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx);

    initial begin
        #2000000;
        n_fail++;
        $display("ERROR %0t: timeout", $time);
        end_sim();
    end

    initial begin
        void'($urandom(32'h013f));
        rst_b = 1'b0;
        power_good = 1'b0;
        supply_ok = 1'b0;
        restart_b = 1'b1;
        quad_en = 1'b0;
        ddr_lat_drive = 1'b0;
        phase = PH_INSTR;
        width = WD_SGL;
        out_data = 4'h0;
        cyc(10);
        rst_b <= 1'b1;
        cyc(8);
        power_good <= 1'b1;
        supply_ok <= 1'b1;
        cyc(PU / 2);
        @(negedge core_clk);
        chk(8'(cmd_ready), 8'h0);
        wait_ready();
        chk(8'(prog_erase_allow), 8'h1);
        $display("TB: cold start done");
        for (int i = 0; i < 4; i++)
            cmd((i == 1) ? 3 : -1, 1'b1);
        $display("TB: instructions done");
        u_host.send(8'h3c, 8, -1);
        exp_q.push_back(8'h3c);
        for (int p = 1; p < 14; p++) begin
            for (int j = 0; j < 3; j++) begin
                @(posedge core_clk);
                phase <= sfis_phase_t'(p);
                width <= sfis_width_t'(j);
                ddr_lat_drive <= j[0];
                out_data <= 4'($urandom);
                u_host.data_line_in <= 4'($urandom);
                @(negedge core_clk);
                e = exp_oe(phase, width, ddr_lat_drive);
                chk(8'(in_bits), 8'(exp_in(phase, width, data_line_in)));
                chk(8'(data_line_oe_b), 8'(e));
                chk(8'(data_line_out & ~e), 8'(out_data & ~e));
                if (p == PH_SGL_OUT) begin
                    u_host.hold_b = 1'b0;
                    @(negedge core_clk);
                    chk(8'(data_line_oe_b), 8'hf);
                    u_host.hold_b = 1'b1;
                end
            end
        end
        u_host.done();
        @(negedge core_clk);
        chk(8'(data_line_oe_b), 8'hf);
        phase <= PH_INSTR;
        u_host.send(8'ha5, 4, -1);
        u_host.done();
        cyc(8);
        chk(8'(exp_q.size()), 8'h0);
        $display("TB: phases done");
        supply_ok <= 1'b0;
        cyc(6);
        @(negedge core_clk);
        chk(8'(core_state), 8'(SFIS_LOCKOUT));
        cmd(-1, 1'b0);
        supply_ok <= 1'b1;
        wait_ready();
        $display("TB: lockout done");
        restart_b <= 1'b0;
        cyc(8);
        @(negedge core_clk);
        chk(8'(core_state), 8'(SFIS_WARM));
        cyc(RS + 4);
        restart_b <= 1'b1;
        @(negedge core_clk);
        chk(8'(cmd_ready), 8'h0);
        wait_ready();
        cmd(-1, 1'b1);
        $display("TB: warm restart done");
        power_good <= 1'b0;
        cyc(8);
        @(negedge core_clk);
        chk(8'(core_state), 8'(SFIS_OFF));
        cmd(-1, 1'b0);
        power_good <= 1'b1;
        wait_ready();
        $display("TB: power off done");
        end_sim();
    end
endmodule : tb
